// *** hdl/dtc_defs.svh ***
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DTC_ADDR_CTRL   8'h88
`define DTC_ADDR_MODE   8'h89
`define DTC_ADDR_A_LO   8'h8A
`define DTC_ADDR_B_LO   8'h8B
`define DTC_ADDR_A_HI   8'h8C
`define DTC_ADDR_B_HI   8'h8D
`define DTC_ADDR_CKSEL  8'h8E
`define DTC_ADDR_ISTAT  8'h90
`define DTC_ADDR_IMASK  8'h91
`define DTC_ADDR_PWR    8'h92
// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define DTC_CTRL_B_OVF  7
`define DTC_CTRL_B_RUN  6
`define DTC_CTRL_A_OVF  5
`define DTC_CTRL_A_RUN  4
`define DTC_CTRL_B_PEND 3
`define DTC_CTRL_B_TRIG 2
`define DTC_CTRL_A_PEND 1
`define DTC_CTRL_A_TRIG 0
// ----------------------------------------
// Mode nibble bits, clock select bits
// ----------------------------------------
`define DTC_MODE_GATE   3
`define DTC_MODE_CSRC   2
`define DTC_CKSEL_B     4
`define DTC_CKSEL_A     3
// ----------------------------------------
// Tick dividers and reset values
// ----------------------------------------
`define DTC_DIV_FAST    4'd4
`define DTC_DIV_SLOW    4'd12
`define DTC_RST_BYTE    8'h00
`define DTC_RST_CKSEL   8'h01
`define DTC_UNMAPPED    8'hFF
`endif

// *** hdl/dtc_pkg.sv ***
package dtc_pkg;
  // Counting modes, from the two mode select bits
  typedef enum logic [1:0] {
    DTC_MODE_PRESCALE,
    DTC_MODE_FULL16,
    DTC_MODE_RELOAD8,
    DTC_MODE_SPLIT
  } dtc_mode_t;
endpackage

// *** hdl/dtc_tick_div.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dtc_defs.svh"
// ----------------------------------------
// Internal tick divider: one pulse per 4 or 12 clocks
// ----------------------------------------
module dtc_tick_div (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Control
  input  wire logic run_i,
  input  wire logic fast_i,
  // Tick out
  output logic      tick_o
);
  logic [3:0] cnt_r;   // Divider phase
  logic [3:0] cnt_nxt;
  logic       tick_r;  // Registered tick
  logic       tick_nxt;
  logic [3:0] limit;   // Divide ratio selected

  // Next phase of the divider
  always_comb begin
    limit    = fast_i ? `DTC_DIV_FAST : `DTC_DIV_SLOW; // [R15]
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (run_i) begin
      if (cnt_r >= limit - 4'd1) begin
        cnt_nxt  = 4'd0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 4'd1;
      end
    end
  end

  // Divider registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r  <= 4'd0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;
endmodule
`default_nettype wire

// *** hdl/dtc_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dtc_defs.svh"
// Summary of operation
// [R1] Overflow sets flag; vector or software clears
// [R2] Run bit turns each timer on/off
// [R3] Pending flag: edge cleared on vector, level tracks
// [R4] Trigger-type bit picks edge or level
// [R5] One means falling edge, zero low level
// [R6] Gate bit: count only while pin high
// [R7] Count-source bit: internal tick or pin falls
// [R8] Upper nibble timer B, lower timer A
// [R9] Mode 00: high byte with 5-bit prescaler
// [R10] Mode 01: sixteen-bit cascade, no prescaler
// [R11] Mode 10: low byte reloads from high
// [R12] Timer A mode 11: split into two bytes
// [R13] Timer B mode 11 stops and holds
// [R14] Split high byte uses timer B run, flag
// [R15] Clock select: divide by 4 or 12
// [R16] Count bytes at 8Ah through 8Dh
// [R17] Idle keeps timers and interrupts running
// [R18] Power-down freezes counts and flags
// [R19] Control 88h, mode 89h, clock select 8Eh
module dtc_timer (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Control register bit write (bit-addressable access)
  input  wire logic       bit_wr_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic       bit_val_i,
  // Interrupt vector acknowledge: 0 ext A, 1 timer A, 2 ext B, 3 timer B
  input  wire logic [3:0] vector_ack_i,
  // Power states
  input  wire logic       cpu_halt_request_i,
  input  wire logic       deep_stop_request_i,
  // External pins
  input  wire logic       count_a_pin_i,
  input  wire logic       count_b_pin_i,
  input  wire logic       ext_irq_a_n_i,
  input  wire logic       ext_irq_b_n_i,
  // Interrupt requests
  output logic      [3:0] irq_req_o,
  output logic            irq_o
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] timer_control_r, timer_control_nxt;
  logic [7:0] timer_mode_r, timer_mode_nxt;
  logic [7:0] a_lo_r, a_lo_nxt;      // Timer A low count
  logic [7:0] a_hi_r, a_hi_nxt;      // Timer A high count
  logic [7:0] b_lo_r, b_lo_nxt;      // Timer B low count
  logic [7:0] b_hi_r, b_hi_nxt;      // Timer B high count
  logic [7:0] clock_select_r, clock_select_nxt;
  logic [3:0] istat_r, istat_nxt;    // Sticky event status
  logic [3:0] imask_r, imask_nxt;    // Interrupt mask
  logic       pwr_r, pwr_nxt;        // Low-power recorded state
  logic [7:0] rdata_r, rdata_nxt;
  logic       irq_r, irq_nxt;

  // ----------------------------------------
  // Pin synchronisers (two flops) and edge history
  // ----------------------------------------
  logic [3:0] sync1_r, sync2_r, prev_r;
  logic [3:0] pins;
  assign pins = {ext_irq_b_n_i, ext_irq_a_n_i, count_b_pin_i, count_a_pin_i};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
      prev_r  <= 4'hF;
    end else if (!deep_stop_request_i) begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Falling edges on the synchronised pins
  logic [3:0] fall;
  assign fall = prev_r & ~sync2_r;

  // ----------------------------------------
  // Internal tick dividers
  // ----------------------------------------
  logic run_clk;  // Clocks stop in power-down, run in idle
  logic tick_a, tick_b;
  assign run_clk = !deep_stop_request_i;  // [R17] [R18]

  dtc_tick_div u_div_a (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .run_i     (run_clk),
    .fast_i    (clock_select_r[`DTC_CKSEL_A]),
    .tick_o    (tick_a)
  );

  dtc_tick_div u_div_b (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .run_i     (run_clk),
    .fast_i    (clock_select_r[`DTC_CKSEL_B]),
    .tick_o    (tick_b)
  );

  // ----------------------------------------
  // Count enables
  // ----------------------------------------
  dtc_pkg::dtc_mode_t mode_a, mode_b;
  logic [3:0] nib_a, nib_b;
  logic       en_a, en_b, inc_a, inc_b, inc_split;

  always_comb begin
    nib_a  = timer_mode_r[3:0];  // [R8]
    nib_b  = timer_mode_r[7:4];  // [R8]
    mode_a = dtc_pkg::dtc_mode_t'(nib_a[1:0]);
    mode_b = dtc_pkg::dtc_mode_t'(nib_b[1:0]);
    // Run bit, optionally gated by the interrupt pin being high
    en_a = timer_control_r[`DTC_CTRL_A_RUN] &
           (~nib_a[`DTC_MODE_GATE] | sync2_r[2]);  // [R2] [R6]
    en_b = timer_control_r[`DTC_CTRL_B_RUN] &
           (~nib_b[`DTC_MODE_GATE] | sync2_r[3]);  // [R2] [R6]
    // Source: internal tick or falling edge of count pin
    inc_a = en_a & (nib_a[`DTC_MODE_CSRC] ? fall[0] : tick_a);  // [R7]
    inc_b = en_b & (nib_b[`DTC_MODE_CSRC] ? fall[1] : tick_b) &
            (mode_b != dtc_pkg::DTC_MODE_SPLIT);               // [R13]
    // Split high byte: timer only, under timer B run bit
    inc_split = timer_control_r[`DTC_CTRL_B_RUN] & tick_a;    // [R12] [R14]
    if (deep_stop_request_i) begin
      inc_a     = 1'b0;  // [R18]
      inc_b     = 1'b0;
      inc_split = 1'b0;
    end
  end

  // ----------------------------------------
  // Counter step per timer
  // ----------------------------------------
  function automatic logic [16:0] step(input dtc_pkg::dtc_mode_t m,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [15:0] v;
    logic [8:0]  s;
    v = 16'h0000;
    s = 9'h000;
    unique case (m)
      dtc_pkg::DTC_MODE_PRESCALE: begin
        // 5-bit prescaler in low byte feeds the high byte
        if (lo[4:0] == 5'h1F) begin
          s = {1'b0, hi} + 9'd1;  // [R9]
          v = {s[7:0], lo[7:5], 5'h00};
        end else begin
          v = {hi, lo[7:5], lo[4:0] + 5'h01};
        end
        step = {s[8], v};
      end
      dtc_pkg::DTC_MODE_FULL16: begin
        step = {1'b0, hi, lo} + 17'd1;  // [R10]
      end
      dtc_pkg::DTC_MODE_RELOAD8, dtc_pkg::DTC_MODE_SPLIT: begin
        s = {1'b0, lo} + 9'd1;
        // Reload from high byte on overflow
        if (s[8] && m == dtc_pkg::DTC_MODE_RELOAD8) begin
          step = {1'b1, hi, hi};  // [R11]
        end else begin
          step = {s[8], hi, s[7:0]};  // [R12]
        end
      end
    endcase
  endfunction

  logic [16:0] nxt_a, nxt_b;
  logic [8:0]  split_hi;
  logic        ovf_a, ovf_b;

  always_comb begin
    nxt_a    = step(mode_a, a_lo_r, a_hi_r);
    nxt_b    = step(mode_b, b_lo_r, b_hi_r);
    split_hi = {1'b0, a_hi_r} + 9'd1;
    ovf_a    = inc_a & nxt_a[16];
    ovf_b    = inc_b & nxt_b[16];
    if (mode_a == dtc_pkg::DTC_MODE_SPLIT) begin
      ovf_b = inc_split & split_hi[8];  // [R14]
    end
  end

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  logic [7:0] ctl;
  logic [3:0] events;
  logic       rd_stat;

  always_comb begin
    timer_control_nxt = timer_control_r;
    timer_mode_nxt    = timer_mode_r;
    a_lo_nxt          = a_lo_r;
    a_hi_nxt          = a_hi_r;
    b_lo_nxt          = b_lo_r;
    b_hi_nxt          = b_hi_r;
    clock_select_nxt  = clock_select_r;
    imask_nxt         = imask_r;
    pwr_nxt           = deep_stop_request_i ? 1'b1 : 1'b0;
    ctl               = timer_control_r;
    rdata_nxt         = 8'h00;
    rd_stat           = 1'b0;
    // Counting
    if (inc_a) begin
      a_lo_nxt = nxt_a[7:0];
      if (mode_a != dtc_pkg::DTC_MODE_SPLIT) begin
        a_hi_nxt = nxt_a[15:8];
      end
    end
    if (mode_a == dtc_pkg::DTC_MODE_SPLIT && inc_split) begin
      a_hi_nxt = split_hi[7:0];  // [R12]
    end
    if (inc_b) begin
      b_lo_nxt = nxt_b[7:0];
      b_hi_nxt = nxt_b[15:8];
    end
    // Register writes
    if (wr_i && !deep_stop_request_i) begin
      unique case (addr_i)
        `DTC_ADDR_CTRL:  ctl = wdata_i;                 // [R19]
        `DTC_ADDR_MODE:  timer_mode_nxt = wdata_i;      // [R19]
        `DTC_ADDR_A_LO:  a_lo_nxt = wdata_i;            // [R16]
        `DTC_ADDR_B_LO:  b_lo_nxt = wdata_i;            // [R16]
        `DTC_ADDR_A_HI:  a_hi_nxt = wdata_i;            // [R16]
        `DTC_ADDR_B_HI:  b_hi_nxt = wdata_i;            // [R16]
        `DTC_ADDR_CKSEL: clock_select_nxt = wdata_i;    // [R19] [R15]
        `DTC_ADDR_IMASK: imask_nxt = wdata_i[3:0];
        default: ;
      endcase
    end
    // Single-bit write to the control register
    if (bit_wr_i && !deep_stop_request_i) begin
      ctl[bit_sel_i] = bit_val_i;  // [R19]
    end
    // Vectoring clears timer flags; ext flags only in edge mode
    // Flags are frozen in power-down, so no vector clear then
    if (!deep_stop_request_i) begin
      if (vector_ack_i[1]) ctl[`DTC_CTRL_A_OVF] = 1'b0;  // [R1] [R18]
      if (vector_ack_i[3]) ctl[`DTC_CTRL_B_OVF] = 1'b0;  // [R1] [R18]
      if (vector_ack_i[0] && ctl[`DTC_CTRL_A_TRIG]) ctl[`DTC_CTRL_A_PEND] = 1'b0;  // [R3]
      if (vector_ack_i[2] && ctl[`DTC_CTRL_B_TRIG]) ctl[`DTC_CTRL_B_PEND] = 1'b0;  // [R3]
    end
    // Hardware set wins over any clear
    if (ovf_a) ctl[`DTC_CTRL_A_OVF] = 1'b1;  // [R1]
    if (ovf_b) ctl[`DTC_CTRL_B_OVF] = 1'b1;  // [R1]
    if (!deep_stop_request_i) begin
      // Edge mode flags a fall; level mode follows the pin
      if (ctl[`DTC_CTRL_A_TRIG]) begin
        if (fall[2]) ctl[`DTC_CTRL_A_PEND] = 1'b1;  // [R5]
      end else begin
        ctl[`DTC_CTRL_A_PEND] = ~sync2_r[2];        // [R4] [R5]
      end
      if (ctl[`DTC_CTRL_B_TRIG]) begin
        if (fall[3]) ctl[`DTC_CTRL_B_PEND] = 1'b1;  // [R5]
      end else begin
        ctl[`DTC_CTRL_B_PEND] = ~sync2_r[3];        // [R4] [R5]
      end
    end
    timer_control_nxt = ctl;
    // Register reads
    if (rd_i) begin
      unique case (addr_i)
        `DTC_ADDR_CTRL:  rdata_nxt = timer_control_r;
        `DTC_ADDR_MODE:  rdata_nxt = timer_mode_r;
        `DTC_ADDR_A_LO:  rdata_nxt = a_lo_r;
        `DTC_ADDR_B_LO:  rdata_nxt = b_lo_r;
        `DTC_ADDR_A_HI:  rdata_nxt = a_hi_r;
        `DTC_ADDR_B_HI:  rdata_nxt = b_hi_r;
        `DTC_ADDR_CKSEL: rdata_nxt = clock_select_r;
        `DTC_ADDR_ISTAT: begin
          rdata_nxt = {4'h0, istat_r};
          rd_stat   = 1'b1;
        end
        `DTC_ADDR_IMASK: rdata_nxt = {4'h0, imask_r};
        `DTC_ADDR_PWR:   rdata_nxt = {6'h00, pwr_r, cpu_halt_request_i};
        default:         rdata_nxt = `DTC_UNMAPPED;
      endcase
    end
    // Sticky status: set wins over read-clear
    events    = {ovf_b, fall[3] & ~deep_stop_request_i,
                 ovf_a, fall[2] & ~deep_stop_request_i};
    istat_nxt = (rd_stat ? 4'h0 : istat_r) | events;
    irq_nxt   = |(istat_nxt & imask_nxt);
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_control_r <= `DTC_RST_BYTE;
      timer_mode_r    <= `DTC_RST_BYTE;
      a_lo_r          <= `DTC_RST_BYTE;
      a_hi_r          <= `DTC_RST_BYTE;
      b_lo_r          <= `DTC_RST_BYTE;
      b_hi_r          <= `DTC_RST_BYTE;
      clock_select_r  <= `DTC_RST_CKSEL;
      istat_r         <= 4'h0;
      imask_r         <= 4'h0;
      pwr_r           <= 1'b0;
      rdata_r         <= 8'h00;
      irq_r           <= 1'b0;
    end else begin
      timer_control_r <= timer_control_nxt;
      timer_mode_r    <= timer_mode_nxt;
      a_lo_r          <= a_lo_nxt;
      a_hi_r          <= a_hi_nxt;
      b_lo_r          <= b_lo_nxt;
      b_hi_r          <= b_hi_nxt;
      clock_select_r  <= clock_select_nxt;
      istat_r         <= istat_nxt;
      imask_r         <= imask_nxt;
      pwr_r           <= pwr_nxt;
      rdata_r         <= rdata_nxt;
      irq_r           <= irq_nxt;
    end
  end

  assign rdata_o   = rdata_r;
  assign irq_o     = irq_r;
  assign irq_req_o = {timer_control_r[`DTC_CTRL_B_OVF], timer_control_r[`DTC_CTRL_B_PEND],
                      timer_control_r[`DTC_CTRL_A_OVF], timer_control_r[`DTC_CTRL_A_PEND]};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_ovf_a_sets;  // [R1]
    @(posedge clk_i) disable iff (!reset_n_i)
      ovf_a |=> timer_control_r[`DTC_CTRL_A_OVF];
  endproperty
  a_ovf_a_sets: assert property (p_ovf_a_sets) else $error("timer A flag not set");

  property p_stop_run;  // [R2]
    @(posedge clk_i) disable iff (!reset_n_i)
      !timer_control_r[`DTC_CTRL_A_RUN] |-> !inc_a;
  endproperty
  a_stop_run: assert property (p_stop_run) else $error("timer A counts while off");

  property p_level_track;  // [R3]
    @(posedge clk_i) disable iff (!reset_n_i || deep_stop_request_i)
      !timer_control_nxt[`DTC_CTRL_A_TRIG] |=>
        timer_control_r[`DTC_CTRL_A_PEND] == ~$past(sync2_r[2]);
  endproperty
  a_level_track: assert property (p_level_track) else $error("level flag off pin");

  property p_gate;  // [R6]
    @(posedge clk_i) disable iff (!reset_n_i)
      (timer_mode_r[`DTC_MODE_GATE] && !sync2_r[2]) |-> !inc_a;
  endproperty
  a_gate: assert property (p_gate) else $error("gated timer A counted");

  property p_b_hold;  // [R13]
    @(posedge clk_i) disable iff (!reset_n_i)
      (timer_mode_r[5:4] == 2'b11 && !wr_i) |=> $stable(b_lo_r) && $stable(b_hi_r);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("timer B moved in mode 11");

  property p_freeze;  // [R18]
    @(posedge clk_i) disable iff (!reset_n_i)
      deep_stop_request_i |=> $stable(a_lo_r) && $stable(a_hi_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("timer A moved in power-down");

  property p_reload;  // [R11]
    @(posedge clk_i) disable iff (!reset_n_i)
      (inc_a && mode_a == dtc_pkg::DTC_MODE_RELOAD8 && a_lo_r == 8'hFF && !wr_i)
        |=> a_lo_r == $past(a_hi_r);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload from high byte");

  property p_read_data;  // [R16]
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `DTC_ADDR_A_HI) |=> rdata_o == $past(a_hi_r);
  endproperty
  a_read_data: assert property (p_read_data) else $error("bad high byte read");
endmodule
`default_nettype wire

// *** sim/dtc_pin_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Far side: count pins and active-low interrupt pins
// ------------------------------------------------------------
module dtc_pin_model (
  // Clock
  input  wire logic       clk_i,
  // Commands from the bench
  input  wire logic [1:0] pulse_i,
  input  wire logic [1:0] irq_low_i,
  // Pins, idle high as with a pull-up
  output logic      [1:0] count_pin_o,
  output logic      [1:0] ext_irq_n_o
);
  // Low time left per count pin: pin A stays low 3 clocks, pin B 6
  logic [2:0] low_r [2];

  // Pins start released
  initial begin
    low_r[0] = 3'h0;
    low_r[1] = 3'h0;
    ext_irq_n_o = 2'h3;
  end

  // One high-to-low edge per command, then back high
  always @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (pulse_i[i]) begin
        low_r[i] <= (i == 0) ? 3'h3 : 3'h6;
      end else if (low_r[i] != 3'h0) begin
        low_r[i] <= low_r[i] - 3'h1;
      end
    end
    // Gate and interrupt level follow the bench
    ext_irq_n_o <= ~irq_low_i;
  end

  assign count_pin_o = {low_r[1] == 3'h0, low_r[0] == 3'h0};
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        bit_wr_i = 1'b0;
  logic [2:0]  bit_sel_i = 3'h0;
  logic        bit_val_i = 1'b0;
  logic [3:0]  vector_ack_i = 4'h0;
  logic        halt_r = 1'b0;
  logic        stop_r = 1'b0;
  logic [1:0]  pulse_r = 2'h0;
  logic [1:0]  irq_low_r = 2'h0;
  logic [1:0]  cnt_pin;
  logic [1:0]  irq_pin_n;
  logic [7:0]  rdata_o;
  logic [3:0]  irq_req_o;
  logic        irq_o;
  logic [15:0] exp_q [$];          // Notes of {tolerance, value}
  logic [15:0] note;
  logic        rd_prev = 1'b0;
  logic [7:0]  rv [4];
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          seed = 46779;

  // Free-running clock
  always #5 clk_i = ~clk_i;

  dtc_pin_model dtc_pin_model_i (
    .clk_i       (clk_i),
    .pulse_i     (pulse_r),
    .irq_low_i   (irq_low_r),
    .count_pin_o (cnt_pin),
    .ext_irq_n_o (irq_pin_n)
  );

  dtc_timer dtc_timer_i (
    .clk_i               (clk_i),
    .reset_n_i           (reset_n_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .rdata_o             (rdata_o),
    .bit_wr_i            (bit_wr_i),
    .bit_sel_i           (bit_sel_i),
    .bit_val_i           (bit_val_i),
    .vector_ack_i        (vector_ack_i),
    .cpu_halt_request_i  (halt_r),
    .deep_stop_request_i (stop_r),
    .count_a_pin_i       (cnt_pin[0]),
    .count_b_pin_i       (cnt_pin[1]),
    .ext_irq_a_n_i       (irq_pin_n[0]),
    .ext_irq_b_n_i       (irq_pin_n[1]),
    .irq_req_o           (irq_req_o),
    .irq_o               (irq_o)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read and note what the data must be
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] t = 8'h00);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back({t, e});
    @(posedge clk_i);
    rd_i   <= 1'b0;
  endtask

  task automatic bw(input logic [2:0] s, input logic v);
    @(posedge clk_i);
    bit_sel_i <= s;
    bit_val_i <= v;
    bit_wr_i  <= 1'b1;
    @(posedge clk_i);
    bit_wr_i  <= 1'b0;
  endtask

  task automatic ack(input int v);
    @(posedge clk_i);
    vector_ack_i[v] <= 1'b1;
    @(posedge clk_i);
    vector_ack_i <= 4'h0;
  endtask

  // Ask the far side for n falling edges, spaced out
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      @(posedge clk_i);
      pulse_r[p] <= 1'b1;
      @(posedge clk_i);
      pulse_r <= 2'h0;
      repeat (12) @(posedge clk_i);
    end
  endtask

  // Bounded wait for a request line
  task automatic wait_req(input int b);
    for (int i = 0; i < 100 && irq_req_o[b] !== 1'b1; i++) @(posedge clk_i);
    chk({7'h00, irq_req_o[b]}, 8'h01);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Read data stands in the cycle after the strobe
  always @(negedge clk_i) begin
    if (rd_prev) begin
      note = exp_q.pop_front();
      if (note[15:8] == 8'hFF || (note[15:8] == 8'h01 &&
          (rdata_o === note[7:0] - 8'h01 || rdata_o === note[7:0] + 8'h01))) begin
        chk(rdata_o, rdata_o);
      end else begin
        chk(rdata_o, note[7:0]);
      end
    end
    rd_prev = rd_i;
  end

  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'h88 + i[7:0], (i == 6) ? 8'h01 : 8'h00);
    rd(8'h87, 8'hFF);
    // Random count bytes, back to back
    for (int i = 0; i < 4; i++) begin
      rv[i] = 8'($random(seed));
      wr(8'h8A + i[7:0], rv[i]);
    end
    for (int i = 0; i < 4; i++) rd(8'h8A + i[7:0], rv[i]);
    // Timer B counter with prescaler
    wr(8'h89, 8'h40);
    wr(8'h8B, 8'h1E);
    wr(8'h8D, 8'h00);
    wr(8'h88, 8'h40);
    pulse(1, 3);
    rd(8'h8D, 8'h01);
    // Timer A counter with reload
    wr(8'h89, 8'h06);
    wr(8'h8C, 8'hFD);
    wr(8'h8A, 8'hFE);
    wr(8'h88, 8'h10);
    pulse(0, 4);
    rd(8'h88, 8'h30);
    rd(8'h8A, 8'hFF);
    rd(8'h8C, 8'hFD);
    bw(3'h5, 1'b0);
    rd(8'h88, 8'h10);
    // Gated counting
    wr(8'h89, 8'h0D);
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'h00);
    irq_low_r <= 2'h1;
    pulse(0, 2);
    irq_low_r <= 2'h0;
    pulse(0, 2);
    rd(8'h8A, 8'h02);
    // Tick rates, sixteen-bit carry, idle
    wr(8'h88, 8'h00);
    wr(8'h8E, 8'h08);
    wr(8'h89, 8'h11);
    wr(8'h8A, 8'hF0);
    wr(8'h8C, 8'h00);
    wr(8'h8B, 8'h00);
    halt_r <= 1'b1;
    rd(8'h92, 8'h01);
    wr(8'h88, 8'h50);
    repeat (118) @(posedge clk_i);
    wr(8'h88, 8'h00);
    halt_r <= 1'b0;
    rd(8'h8A, 8'h0E, 8'h01);
    rd(8'h8C, 8'h01);
    rd(8'h8B, 8'h0A, 8'h01);
    // Power-down freezes flags and writes
    wr(8'h8A, 8'h44);
    wr(8'h88, 8'h20);
    stop_r <= 1'b1;
    repeat (2) @(posedge clk_i);
    wr(8'h8A, 8'h33);
    ack(1);
    rd(8'h88, 8'h20);
    rd(8'h8A, 8'h44);
    rd(8'h92, 8'h02);
    stop_r <= 1'b0;
    ack(1);
    rd(8'h88, 8'h00);
    // Split mode, timer B held
    wr(8'h89, 8'h33);
    wr(8'h8B, 8'h55);
    wr(8'h8A, 8'h11);
    wr(8'h8C, 8'hFE);
    wr(8'h88, 8'h40);
    wait_req(3);
    rd(8'h8A, 8'h11);
    rd(8'h8B, 8'h55);
    rd(8'h88, 8'hC0);
    ack(3);
    rd(8'h88, 8'h40);
    // External interrupt, edge then level
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'h91, 8'h00);
    rd(8'h90, 8'h0B);
    wr(8'h88, 8'h01);
    irq_low_r <= 2'h1;
    repeat (8) @(posedge clk_i);
    rd(8'h88, 8'h03);
    chk({7'h00, irq_o}, 8'h00);
    wr(8'h91, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h01);
    rd(8'h90, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h00);
    ack(0);
    rd(8'h88, 8'h01);
    irq_low_r <= 2'h0;
    repeat (8) @(posedge clk_i);
    wr(8'h88, 8'h00);
    irq_low_r <= 2'h1;
    repeat (8) @(posedge clk_i);
    rd(8'h88, 8'h02);
    ack(0);
    rd(8'h88, 8'h02);
    irq_low_r <= 2'h0;
    repeat (8) @(posedge clk_i);
    rd(8'h88, 8'h00);
    repeat (4) @(posedge clk_i);
    conclude();
  end
endmodule
`default_nettype wire
